//--- core/sfr_regs.svh
/*
 * Constants of the discovery parameter table: identifiers, lengths, base addresses,
 * byte offsets and fixed contents.
 * Assumes it is included by bare name from core/ design files.
 */
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// Parameter identifiers and header
`define SFR_ID_PAD          8'hf0
`define SFR_ID_BASIC        8'ha5
`define SFR_LEN_BASIC       8'h80
`define SFR_OFF_ID          16'h0000
`define SFR_OFF_LEN         16'h0001
`define SFR_HDR_SKIP        16'h0002
`define SFR_FILL            8'hff

// Discovery address space
`define SFR_BASIC_BASE      16'h1120
`define SFR_ENTRY_BASE      16'h111e
`define SFR_PAD_BASE        16'h1100
`define SFR_PAD_LEN_DEF     8'h1c
`define SFR_ADDR_STEP       16'h0001
`define SFR_ADDR_RESET      16'h0000
`define SFR_ADDR_TOP        16'hffff

// Basic table byte offsets
`define SFR_B_DW1_B0        16'h0000
`define SFR_B_DW1_B1        16'h0001
`define SFR_B_DW1_B2        16'h0002
`define SFR_B_DW1_B3        16'h0003
`define SFR_B_DW2_B0        16'h0004
`define SFR_B_DW2_B3        16'h0007
`define SFR_B_DW3_B0        16'h0008
`define SFR_B_DW3_B1        16'h0009
`define SFR_B_DW3_B2        16'h000a
`define SFR_B_DW3_B3        16'h000b

// Basic dword 1 byte 0 fields
`define SFR_DW1_UNUSED      3'b111
`define SFR_DW1_SR_NV       2'b00
`define SFR_DW1_BUF64       1'b1
`define SFR_DW1_NO4K        2'b11
// Basic dword 1 byte 2 fields
`define SFR_DW1_B2_UNUSED   1'b1
`define SFR_DW1_QOUT        1'b1
`define SFR_DW1_QIO         1'b1
`define SFR_DW1_DIO         1'b1
`define SFR_DW1_DDR         1'b0
`define SFR_DW1_ADDR34      2'b01
`define SFR_DW1_DOUT        1'b1
// Density and dword 3
`define SFR_DENSITY_MSB     8'h07
`define SFR_QIO_MODE        3'b010
`define SFR_QIO_DUMMY       5'b00100
`define SFR_QIO_OPCODE      8'heb
`define SFR_QOUT_MODE       3'b000
`define SFR_QOUT_DUMMY      5'b01000
`define SFR_QOUT_OPCODE     8'h6b

`endif

//--- core/sfr_pkg.sv
/*
 * Types of the discovery parameter table.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sfr_pkg;
	typedef enum logic [1:0] {
		SFR_ST_IDLE   = 2'b00,
		SFR_ST_STREAM = 2'b01
	} sfr_state_e_t;

	typedef struct packed {
		sfr_state_e_t state;
		logic [15:0]  addr;
		logic [7:0]   data;
		logic         valid;
		logic         in_table;
		logic         wr_ignored;
	} sfr_state_t;
endpackage

//--- core/sfr_lookup.sv
/*
 * Combinational byte lookup of the fixed discovery table: one padding parameter
 * followed by the basic discoverable parameter entry.
 * Assumes an absolute discovery address from logic on the same clock.
 */
`timescale 1ns/1ps
`include "sfr_regs.svh"
module sfr_lookup #(
	parameter logic [7:0] PAD_LEN = `SFR_PAD_LEN_DEF
) (
	input  wire logic [15:0] i_addr,
	output logic      [7:0]  o_data,
	output logic             o_hit
);
	logic [15:0] entry_off;
	logic [15:0] pad_off;

	function automatic logic [7:0] basic_byte(input logic [15:0] off);
		logic [7:0] b;
		b = `SFR_FILL;
		case (off)
			`SFR_B_DW1_B0: b = {`SFR_DW1_UNUSED, `SFR_DW1_SR_NV, `SFR_DW1_BUF64, `SFR_DW1_NO4K}; // R6
			`SFR_B_DW1_B1: b = `SFR_FILL; // R7
			`SFR_B_DW1_B2: b = {`SFR_DW1_B2_UNUSED, `SFR_DW1_QOUT, `SFR_DW1_QIO, `SFR_DW1_DIO,
				`SFR_DW1_DDR, `SFR_DW1_ADDR34, `SFR_DW1_DOUT}; // R8
			`SFR_B_DW1_B3: b = `SFR_FILL; // R9
			`SFR_B_DW2_B3: b = `SFR_DENSITY_MSB; // R10
			`SFR_B_DW3_B0: b = {`SFR_QIO_MODE, `SFR_QIO_DUMMY}; // R11
			`SFR_B_DW3_B1: b = `SFR_QIO_OPCODE; // R12
			`SFR_B_DW3_B2: b = {`SFR_QOUT_MODE, `SFR_QOUT_DUMMY}; // R13
			`SFR_B_DW3_B3: b = `SFR_QOUT_OPCODE; // R14
			// Density low bytes and every byte of the entry after dword 3 read all ones
			default:       b = `SFR_FILL; // R10
		endcase
		return b;
	endfunction

	always_comb begin
		entry_off = i_addr - `SFR_ENTRY_BASE;
		pad_off   = i_addr - `SFR_PAD_BASE;
		o_data    = `SFR_FILL;
		o_hit     = 1'b0;
		// Entry spans its id byte, its length byte and the length bytes that follow
		if (i_addr >= `SFR_ENTRY_BASE && entry_off <= ({8'h00, `SFR_LEN_BASIC} + `SFR_OFF_LEN)) begin
			o_hit = 1'b1;
			case (entry_off)
				`SFR_OFF_ID:  o_data = `SFR_ID_BASIC; // R3
				`SFR_OFF_LEN: o_data = `SFR_LEN_BASIC; // R4
				default:      o_data = basic_byte(entry_off - `SFR_HDR_SKIP); // R5
			endcase
		end else if (i_addr >= `SFR_PAD_BASE && pad_off <= ({8'h00, PAD_LEN} + `SFR_OFF_LEN)) begin
			o_hit = 1'b1;
			case (pad_off)
				`SFR_OFF_ID:  o_data = `SFR_ID_PAD; // R1
				`SFR_OFF_LEN: o_data = PAD_LEN; // R1
				// Padding body holds no capability data
				default:      o_data = `SFR_FILL; // R2
			endcase
		end
	end
endmodule

//--- core/sfr_rom.sv
/*
 * Read-only discovery parameter table of a serial flash: answers byte reads by
 * absolute discovery address or relative to the basic table, with an
 * auto-incrementing stream as a serial read would use.
 * Assumes requests come from the command decoder on the same clock; writes from
 * that decoder are flagged and never touch the content.
 */
`timescale 1ns/1ps
`include "sfr_regs.svh"
// Notes on behaviour
// R1: The padding identifier may occur many times with differing lengths and a reader skips it by its length byte.
// R2: Padding only reserves space or aligns the next parameter and carries no capability data.
// R3: Entry byte zero returns the identifier of the basic discoverable parameter block.
// R4: Entry byte one returns how many bytes follow, so the next parameter starts at that location plus count plus one.
// R5: Basic content starts at entry byte two, which is also discovery address 1120h.
// R6: Basic dword 1 byte 0 reads E7h from its unused, status, buffer and erase fields.
// R7: Basic dword 1 byte 1 reads all ones since no uniform small erase opcode exists.
// R8: Basic dword 1 byte 2 reads F3h giving the supported read modes and the address byte choice.
// R9: Basic dword 1 byte 3 always reads all ones.
// R10: Basic dword 2 is density in bits minus one, bytes FFh FFh FFh 07h in ascending order.
// R11: Basic dword 3 byte 0 reads 44h, two quad I/O mode cycles and four dummy cycles.
// R12: Basic dword 3 byte 1 returns the quad I/O read opcode.
// R13: Basic dword 3 byte 2 reads 08h, no quad output mode cycles and eight dummy cycles.
// R14: Basic dword 3 byte 3 returns the quad output read opcode.
// R15: The whole table is fixed and every read returns the same value whatever came before.
module sfr_rom #(
	parameter logic [7:0] PAD_LEN = `SFR_PAD_LEN_DEF
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	input  wire logic        i_rd_start,
	input  wire logic [15:0] i_rd_addr,
	input  wire logic        i_basic_rel,
	input  wire logic        i_rd_next,
	input  wire logic        i_rd_stop,
	input  wire logic        i_wr_valid,
	output logic      [7:0]  o_rd_data,
	output logic             o_rd_valid,
	output logic      [15:0] o_addr_cur,
	output logic             o_in_table,
	output logic             o_busy,
	output logic             o_wr_ignored
);
	sfr_pkg::sfr_state_t st;
	sfr_pkg::sfr_state_t next_st;
	logic [15:0]         look_addr;
	logic [15:0]         start_abs;
	logic [7:0]          look_data;
	logic                look_hit;

	// Basic-relative requests land on the same bytes as the absolute alias
	assign start_abs = i_basic_rel ? (`SFR_BASIC_BASE + i_rd_addr) : i_rd_addr; // R5

	sfr_lookup #(
		.PAD_LEN (PAD_LEN)
	) sfr_lookup_inst (
		.i_addr (look_addr),
		.o_data (look_data),
		.o_hit  (look_hit)
	);

	always_comb begin
		next_st            = st;
		next_st.valid      = 1'b0;
		next_st.wr_ignored = 1'b0;
		look_addr          = st.addr;
		// A write only raises a flag; the content has no write path
		if (i_wr_valid) begin
			next_st.wr_ignored = 1'b1; // R15
		end
		if (i_rd_start) begin
			look_addr        = start_abs;
			next_st.state    = sfr_pkg::SFR_ST_STREAM;
			next_st.addr     = start_abs;
			next_st.data     = look_data;
			next_st.in_table = look_hit;
			next_st.valid    = 1'b1;
		end else begin
			case (st.state)
				sfr_pkg::SFR_ST_IDLE: begin
					next_st.state = sfr_pkg::SFR_ST_IDLE;
				end
				sfr_pkg::SFR_ST_STREAM: begin
					if (i_rd_stop) begin
						next_st.state = sfr_pkg::SFR_ST_IDLE;
					end else if (i_rd_next) begin
						// Stream wraps at the top of the address space
						look_addr        = st.addr + `SFR_ADDR_STEP;
						next_st.addr     = look_addr;
						next_st.data     = look_data;
						next_st.in_table = look_hit;
						next_st.valid    = 1'b1;
					end
				end
				default: begin
					next_st.state = sfr_pkg::SFR_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			st.state      <= sfr_pkg::SFR_ST_IDLE;
			st.addr       <= `SFR_ADDR_RESET;
			st.data       <= `SFR_FILL;
			st.valid      <= 1'b0;
			st.in_table   <= 1'b0;
			st.wr_ignored <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rd_data    = st.data;
	assign o_rd_valid   = st.valid;
	assign o_addr_cur   = st.addr;
	assign o_in_table   = st.in_table;
	assign o_busy       = (st.state == sfr_pkg::SFR_ST_STREAM);
	assign o_wr_ignored = st.wr_ignored;

	// Checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);

	property p_abs_read(logic [15:0] a, logic [7:0] d);
		i_rd_start && !i_basic_rel && i_rd_addr == a |=> o_rd_valid && o_rd_data == d && o_addr_cur == a;
	endproperty

	property p_rel_read(logic [15:0] a, logic [7:0] d);
		i_rd_start && i_basic_rel && i_rd_addr == a |=> o_rd_valid && o_rd_data == d && o_in_table;
	endproperty

	// Padding parameter
	a_pad_header: assert property ( // R1
		i_rd_start && !i_basic_rel && i_rd_addr == `SFR_PAD_BASE && !i_rd_stop
		##1 i_rd_next && !i_rd_start && !i_rd_stop
		|-> o_rd_data == `SFR_ID_PAD ##1 o_rd_valid && o_rd_data == PAD_LEN
	) else $error("padding header bytes wrong");

	a_pad_id_abs: assert property (p_abs_read(`SFR_PAD_BASE, `SFR_ID_PAD)) // R1
		else $error("padding identifier wrong");

	a_pad_len_abs: assert property ( // R1
		p_abs_read(`SFR_PAD_BASE + `SFR_OFF_LEN, PAD_LEN)
	) else $error("padding length wrong");

	// Body bytes follow the padding length, so a shorter padding leaves a gap that is not checked here
	a_pad_body_fill: assert property ( // R2
		i_rd_start && !i_basic_rel && i_rd_addr > (`SFR_PAD_BASE + `SFR_OFF_LEN)
		&& i_rd_addr <= (`SFR_PAD_BASE + {8'h00, PAD_LEN} + `SFR_OFF_LEN)
		&& i_rd_addr < `SFR_ENTRY_BASE
		|=> o_rd_data == `SFR_FILL && o_in_table
	) else $error("padding body not all ones");

	// An overlap with the entry yields to the entry, which is still in the table
	a_pad_in_table: assert property ( // R2
		i_rd_start && !i_basic_rel && i_rd_addr >= `SFR_PAD_BASE
		&& i_rd_addr <= (`SFR_PAD_BASE + {8'h00, PAD_LEN} + `SFR_OFF_LEN)
		|=> o_in_table
	) else $error("padding byte not inside the table");

	a_below_pad: assert property (
		i_rd_start && !i_basic_rel && i_rd_addr < `SFR_PAD_BASE
		|=> !o_in_table && o_rd_data == `SFR_FILL
	) else $error("unmapped byte below the table wrong");

	// Basic entry header
	a_entry_id: assert property (p_abs_read(`SFR_ENTRY_BASE, `SFR_ID_BASIC)) // R3
		else $error("entry identifier wrong");

	a_entry_len: assert property ( // R4
		p_abs_read(`SFR_ENTRY_BASE + `SFR_OFF_LEN, `SFR_LEN_BASIC)
	) else $error("entry length wrong");

	// The last byte counted by the length byte still belongs to the entry
	a_entry_end: assert property ( // R4
		i_rd_start && !i_basic_rel
		&& i_rd_addr == (`SFR_ENTRY_BASE + {8'h00, `SFR_LEN_BASIC} + `SFR_OFF_LEN)
		|=> o_rd_data == `SFR_FILL && o_in_table
	) else $error("entry end byte wrong");

	a_after_entry: assert property ( // R4
		i_rd_start && !i_basic_rel
		&& i_rd_addr > (`SFR_ENTRY_BASE + {8'h00, `SFR_LEN_BASIC} + `SFR_OFF_LEN)
		&& i_rd_addr > (`SFR_PAD_BASE + {8'h00, PAD_LEN} + `SFR_OFF_LEN)
		|=> !o_in_table && o_rd_data == `SFR_FILL
	) else $error("byte past the entry still in the table");

	// Basic table content, by offset and by absolute address
	a_basic_alias: assert property ( // R5
		i_rd_start && i_basic_rel && i_rd_addr == `SFR_B_DW1_B0
		|=> o_addr_cur == `SFR_BASIC_BASE && o_rd_data == {`SFR_DW1_UNUSED, `SFR_DW1_SR_NV,
			`SFR_DW1_BUF64, `SFR_DW1_NO4K}
	) else $error("basic table alias wrong");

	a_abs_alias: assert property ( // R5
		p_abs_read(`SFR_BASIC_BASE + `SFR_B_DW3_B1, `SFR_QIO_OPCODE)
	) else $error("basic byte at its absolute address wrong");

	a_dw1_byte0: assert property (p_rel_read(`SFR_B_DW1_B0, 8'he7)) // R6
		else $error("dword 1 byte 0 wrong");

	a_dw1_byte1: assert property (p_rel_read(`SFR_B_DW1_B1, `SFR_FILL)) // R7
		else $error("dword 1 byte 1 wrong");

	a_dw1_byte2: assert property (p_rel_read(`SFR_B_DW1_B2, 8'hf3)) // R8
		else $error("dword 1 byte 2 wrong");

	a_dw1_byte3: assert property (p_rel_read(`SFR_B_DW1_B3, `SFR_FILL)) // R9
		else $error("dword 1 byte 3 wrong");

	a_dw2_byte0: assert property (p_rel_read(`SFR_B_DW2_B0, `SFR_FILL)) // R10
		else $error("density low byte wrong");

	a_dw2_byte3: assert property (p_rel_read(`SFR_B_DW2_B3, `SFR_DENSITY_MSB)) // R10
		else $error("density high byte wrong");

	// Checked at the third next: two older answers through the past, the newest two in order
	a_density_bytes: assert property ( // R10
		i_rd_start && i_basic_rel && i_rd_addr == `SFR_B_DW2_B0 && !i_rd_stop
		##1 (i_rd_next && !i_rd_start && !i_rd_stop) [*3]
		|-> $past(o_rd_data, 2) == `SFR_FILL && $past(o_rd_data) == `SFR_FILL
			&& o_rd_data == `SFR_FILL ##1 o_rd_data == `SFR_DENSITY_MSB
	) else $error("density bytes wrong");

	a_dw3_byte0: assert property (p_rel_read(`SFR_B_DW3_B0, 8'h44)) // R11
		else $error("dword 3 byte 0 wrong");

	a_dw3_byte1: assert property (p_rel_read(`SFR_B_DW3_B1, `SFR_QIO_OPCODE)) // R12
		else $error("dword 3 byte 1 wrong");

	a_dw3_byte2: assert property (p_rel_read(`SFR_B_DW3_B2, 8'h08)) // R13
		else $error("dword 3 byte 2 wrong");

	a_dw3_byte3: assert property (p_rel_read(`SFR_B_DW3_B3, `SFR_QOUT_OPCODE)) // R14
		else $error("dword 3 byte 3 wrong");

	a_quad_io: assert property ( // R11 R12
		i_rd_start && i_basic_rel && i_rd_addr == `SFR_B_DW3_B0 && !i_rd_stop
		##1 i_rd_next && !i_rd_start && !i_rd_stop
		|-> o_rd_data == 8'h44 ##1 o_rd_data == `SFR_QIO_OPCODE
	) else $error("quad io bytes wrong");

	a_quad_out: assert property ( // R13 R14
		i_rd_start && i_basic_rel && i_rd_addr == `SFR_B_DW3_B2 && !i_rd_stop
		##1 i_rd_next && !i_rd_start && !i_rd_stop
		|-> o_rd_data == 8'h08 ##1 o_rd_data == `SFR_QOUT_OPCODE
	) else $error("quad output bytes wrong");

	// Fixed content and ignored writes
	a_read_fixed: assert property ( // R15
		o_rd_valid && $past(o_rd_valid) && o_addr_cur == $past(o_addr_cur)
		|-> o_rd_data == $past(o_rd_data)
	) else $error("repeated read returned a different byte");

	a_write_flag: assert property ( // R15
		i_wr_valid && !i_rd_start && !i_rd_next
		|=> o_wr_ignored && !o_rd_valid && o_addr_cur == $past(o_addr_cur)
	) else $error("write disturbed the table");

	a_write_data: assert property ( // R15
		i_wr_valid && !i_rd_start && !i_rd_next |=> $stable(o_rd_data) && $stable(o_in_table)
	) else $error("write changed the returned byte");

	a_wr_pulse: assert property (!i_wr_valid |=> !o_wr_ignored)
		else $error("write flag without a write");

	// Stream handshake
	a_start_busy: assert property (i_rd_start |=> o_busy && o_rd_valid)
		else $error("start did not open a stream");

	a_valid_pulse: assert property (
		!i_rd_start && !(o_busy && i_rd_next && !i_rd_stop) |=> !o_rd_valid
	) else $error("answer without a taken request");

	a_idle_next: assert property (
		!o_busy && i_rd_next && !i_rd_start |=> !o_rd_valid && !o_busy
	) else $error("next while idle was answered");

	a_restart_addr: assert property (
		o_busy && i_rd_start && !i_basic_rel |=> o_addr_cur == $past(i_rd_addr)
	) else $error("restart did not move to the new address");

	a_stream_step: assert property (
		o_busy && i_rd_next && !i_rd_start && !i_rd_stop
		|=> o_rd_valid && o_addr_cur == $past(o_addr_cur) + `SFR_ADDR_STEP
	) else $error("stream did not advance by one");

	// The wrapped byte lies outside the table, so a host walking off the top sees fill
	a_wrap_top: assert property (
		o_busy && i_rd_next && !i_rd_start && !i_rd_stop && o_addr_cur == `SFR_ADDR_TOP
		|=> o_addr_cur == `SFR_ADDR_RESET && !o_in_table && o_rd_data == `SFR_FILL
	) else $error("stream did not wrap to the bottom");

	a_stop_idle: assert property (
		i_rd_stop && !i_rd_start |=> !o_busy && !o_rd_valid
	) else $error("stop did not end the stream");

	a_stop_keeps: assert property (
		o_busy && i_rd_stop && !i_rd_start |=> $stable(o_rd_data) && $stable(o_addr_cur)
	) else $error("stop changed the last answer");

	a_hold_idle: assert property (
		!o_busy && !i_rd_start |=> $stable(o_rd_data) && $stable(o_addr_cur) && $stable(o_in_table)
	) else $error("idle table changed its answer");

	c_pad_then_entry: cover property (
		o_rd_valid && o_rd_data == `SFR_ID_PAD ##[1:40] o_rd_valid && o_rd_data == `SFR_ID_BASIC
	);
	c_rel_start: cover property (i_rd_start && i_basic_rel);
	c_write_ignored: cover property (o_wr_ignored);
	c_opcode_read: cover property (o_rd_valid && o_rd_data == `SFR_QOUT_OPCODE);
	c_restart: cover property (o_busy && i_rd_start);
endmodule

//--- sim/sfr_host_model.sv
/*
 * Host model for the discovery table: byte and stream reads, write attempts, parameter walk.
 * Assumes the table answers one cycle after a taken request, on the same clock.
 */
`timescale 1ns/1ps
module sfr_host_model (
	input  wire logic        i_clk_sys,
	input  wire logic [7:0]  i_rd_data,
	input  wire logic        i_rd_valid,
	output logic             o_rd_start,
	output logic      [15:0] o_rd_addr,
	output logic             o_basic_rel,
	output logic             o_rd_next,
	output logic             o_rd_stop,
	output logic             o_wr_valid
);
	initial begin
		o_rd_start = 1'b0;
		o_rd_addr = 16'h0000;
		o_basic_rel = 1'b0;
		o_rd_next = 1'b0;
		o_rd_stop = 1'b0;
		o_wr_valid = 1'b0;
	end

	// Start, n-1 nexts back to back, then stop; a missing answer is queued as unknown
	task automatic rd(input logic [15:0] a, input logic rel, input int n, output logic [7:0] q[$]);
		q = {};
		@(posedge i_clk_sys);
		#1;
		o_rd_start = 1'b1;
		o_rd_addr = a;
		o_basic_rel = rel;
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk_sys);
			#1;
			o_rd_start = 1'b0;
			// Address is no longer qualified, so it must not keep the old value
			o_rd_addr = ~a;
			o_rd_next = (i < n - 1);
			q.push_back(i_rd_valid === 1'b1 ? i_rd_data : 8'hxx);
		end
		o_rd_stop = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_rd_stop = 1'b0;
	endtask

	// Two starts at one address back to back: the second restarts the open stream
	task automatic rd_twice(input logic [15:0] a, input logic rel, output logic [7:0] q[$]);
		q = {};
		@(posedge i_clk_sys);
		#1;
		o_rd_start = 1'b1;
		o_rd_addr = a;
		o_basic_rel = rel;
		@(posedge i_clk_sys);
		#1;
		q.push_back(i_rd_valid === 1'b1 ? i_rd_data : 8'hxx);
		@(posedge i_clk_sys);
		#1;
		o_rd_start = 1'b0;
		o_rd_addr = ~a;
		o_rd_stop = 1'b1;
		q.push_back(i_rd_valid === 1'b1 ? i_rd_data : 8'hxx);
		@(posedge i_clk_sys);
		#1;
		o_rd_stop = 1'b0;
	endtask

	task automatic wr();
		@(posedge i_clk_sys);
		#1;
		o_wr_valid = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_wr_valid = 1'b0;
	endtask

	task automatic nudge();
		@(posedge i_clk_sys);
		#1;
		o_rd_next = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_rd_next = 1'b0;
	endtask

	// Skip parameters by their length byte until the basic entry id shows up
	task automatic find_basic(output logic [15:0] loc);
		logic [7:0] q[$];
		logic       found;
		found = 1'b0;
		loc = 16'h1100;
		for (int k = 0; k < 4 && !found; k++) begin
			rd(loc, 1'b0, 2, q);
			if (q[0] === 8'ha5)
				found = 1'b1;
			else
				loc = loc + 16'h0002 + {8'h00, q[1]};
		end
		if (!found)
			loc = 16'hffff;
	endtask
endmodule

//--- sim/tb_sfr_rom.sv
/*
 * Self-checking bench of the discovery table: row table, stream, write, idle next, walk, reset.
 * Assumes the host model drives every request input of the table.
 */
`timescale 1ns/1ps
module tb_sfr_rom;
	typedef struct packed {
		logic [15:0] a;
		logic        rel;
		logic [7:0]  d;
		logic        t;
	} sfr_row_t;

	logic        clk;
	logic        rst;
	logic        start;
	logic [15:0] addr;
	logic        rel;
	logic        nxt;
	logic        stp;
	logic        wr;
	logic [7:0]  rd_data;
	logic        rd_valid;
	logic [15:0] addr_cur;
	logic        in_table;
	logic        busy;
	logic        wr_ign;
	int          error_cnt = 0;
	int          check_count = 0;
	logic [7:0]  q[$];
	logic [15:0] loc;

	const sfr_row_t rows [20] = '{
		'{16'h1100, 1'b0, 8'hf0, 1'b1}, '{16'h1101, 1'b0, 8'h1c, 1'b1}, '{16'h1102, 1'b0, 8'hff, 1'b1},
		'{16'h111d, 1'b0, 8'hff, 1'b1}, '{16'h111e, 1'b0, 8'ha5, 1'b1}, '{16'h111f, 1'b0, 8'h80, 1'b1},
		'{16'h1120, 1'b0, 8'he7, 1'b1}, '{16'h0000, 1'b1, 8'he7, 1'b1}, '{16'h0001, 1'b1, 8'hff, 1'b1},
		'{16'h0002, 1'b1, 8'hf3, 1'b1}, '{16'h0003, 1'b1, 8'hff, 1'b1}, '{16'h0007, 1'b1, 8'h07, 1'b1},
		'{16'h0008, 1'b1, 8'h44, 1'b1}, '{16'h000b, 1'b1, 8'h6b, 1'b1}, '{16'h2000, 1'b0, 8'hff, 1'b0},
		'{16'h1129, 1'b0, 8'heb, 1'b1}, '{16'h119f, 1'b0, 8'hff, 1'b1}, '{16'h11a0, 1'b0, 8'hff, 1'b0},
		'{16'h10ff, 1'b0, 8'hff, 1'b0}, '{16'h0009, 1'b1, 8'heb, 1'b1}};
	const logic [7:0] exp_basic [12] = '{8'he7, 8'hff, 8'hf3, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07,
		8'h44, 8'heb, 8'h08, 8'h6b};

	sfr_rom #(.PAD_LEN(8'h1c)) sfr_rom_inst (
		.i_clk_sys(clk), .i_reset(rst), .i_rd_start(start), .i_rd_addr(addr), .i_basic_rel(rel),
		.i_rd_next(nxt), .i_rd_stop(stp), .i_wr_valid(wr), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.o_addr_cur(addr_cur), .o_in_table(in_table), .o_busy(busy), .o_wr_ignored(wr_ign));

	sfr_host_model sfr_host_model_inst (
		.i_clk_sys(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_rd_start(start),
		.o_rd_addr(addr), .o_basic_rel(rel), .o_rd_next(nxt), .o_rd_stop(stp), .o_wr_valid(wr));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Whole run needs about 120 cycles
	initial begin
		#(25 * 4000);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		rst = 1'b1;
		repeat (10) @(posedge clk);
		chk("reset outputs", {rd_data, rd_valid, addr_cur, in_table, busy, wr_ign}, 28'hff00000);
		#1;
		rst = 1'b0;
		foreach (rows[i]) begin
			sfr_host_model_inst.rd(rows[i].a, rows[i].rel, 1, q);
			chk("row byte", q[0], rows[i].d);
			chk("row place", {addr_cur, in_table, busy},
				{rows[i].rel ? 16'h1120 + rows[i].a : rows[i].a, rows[i].t, 1'b0});
		end
		sfr_host_model_inst.rd(16'h0000, 1'b1, 12, q);
		foreach (exp_basic[i])
			chk("stream byte", q[i], exp_basic[i]);
		chk("stream end", addr_cur, 16'h112b);
		sfr_host_model_inst.wr();
		chk("write flag", wr_ign, 1'b1);
		sfr_host_model_inst.rd(16'h0008, 1'b1, 4, q);
		chk("dword 3 after write", {q[0], q[1], q[2], q[3]}, 32'h44eb086b);
		sfr_host_model_inst.nudge();
		chk("idle next", {rd_valid, busy}, 2'b00);
		sfr_host_model_inst.find_basic(loc);
		chk("walk to entry", loc, 16'h111e);
		sfr_host_model_inst.rd(16'h0004, 1'b1, 4, q);
		chk("density bytes", {q[0], q[1], q[2], q[3]}, 32'hffffff07);
		sfr_host_model_inst.rd_twice(16'h111e, 1'b0, q);
		chk("repeated start", {q[0], q[1]}, 16'ha5a5);
		chk("restart place", addr_cur, 16'h111e);
		sfr_host_model_inst.rd(16'hffff, 1'b0, 2, q);
		chk("wrap bytes", {q[0], q[1]}, 16'hffff);
		chk("wrap place", {addr_cur, in_table}, 17'h00000);
		@(posedge clk);
		#1;
		rst = 1'b1;
		@(posedge clk);
		#1;
		chk("second reset", {rd_data, rd_valid, addr_cur, in_table, busy, wr_ign}, 28'hff00000);
		rst = 1'b0;
		sfr_host_model_inst.rd(16'h000a, 1'b1, 2, q);
		chk("read after reset", {q[0], q[1]}, 16'h086b);
		tally_and_finish();
	end
endmodule
